// ### src/pcq_pkg.sv
// shared constants and types for the pulse counter
package pcq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CNT    = 8'h0c;
    localparam logic [7:0] OFS_TOP    = 8'h10;
    localparam logic [7:0] OFS_WRAP_LIMIT_BUFFER   = 8'h14;
    localparam logic [7:0] OFS_IF     = 8'h18;
    localparam logic [7:0] OFS_IFS    = 8'h1c;
    localparam logic [7:0] OFS_IFC    = 8'h20;
    localparam logic [7:0] OFS_IEN    = 8'h24;
    localparam logic [7:0] OFS_ROUTE  = 8'h28;
    localparam logic [7:0] OFS_FREEZE = 8'h2c;
    localparam logic [7:0] OFS_SYNC   = 8'h30;
    localparam logic [7:0] OFS_AUX    = 8'h38;
    localparam logic [7:0] OFS_INPUT  = 8'h3c;

    // control field positions
    localparam int MODE_LO   = 0;
    localparam int DIR_BIT   = 2;
    localparam int EDGE_BIT  = 3;
    localparam int PULSE_WIDTH_GUARD_BIT  = 4;
    localparam int RST_BIT   = 5;
    localparam int MIDPOINT_WRAP_ENABLE_BIT  = 8;
    localparam int S1DIR_BIT = 9;
    localparam int MAIN_COUNT_EVENTS_LO  = 10;
    localparam int AUXEV_LO  = 14;

    // command bits
    localparam int CMD_LCNT = 0;
    localparam int CMD_LTOP = 1;

    // input register fields
    localparam int SEL_LO    = 0;
    localparam int SEL_W     = 4;
    localparam int S0EN_BIT  = 6;
    localparam int S1EN_BIT  = 10;

    // flag bits
    localparam int F_UF  = 0;
    localparam int F_OF  = 1;
    localparam int F_DIR = 2;
    localparam int F_AUX = 3;
    localparam int NFLAG = 4;

    // reset values
    localparam logic [15:0] TOP_RST  = 16'h00ff;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // filter length and domain reset release depth
    localparam int PULSE_WIDTH_GUARD_CYC = 5;
    localparam int RST_SYNC = 2;

    typedef enum logic [1:0] {
        PCQ_DISABLE,
        PCQ_SAMPLED,
        PCQ_PINCLK,
        PCQ_QUAD
    } pcq_mode_e;

    // events (main counter) selections
    localparam logic [1:0] EV_BOTH = 2'h0;
    localparam logic [1:0] EV_UP   = 2'h1;
    localparam logic [1:0] EV_DOWN = 2'h2;

    // secondary counter selections
    localparam logic [1:0] AX_UP   = 2'h1;
    localparam logic [1:0] AX_DOWN = 2'h2;
    localparam logic [1:0] AX_BOTH = 2'h3;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcq_bus_s;
endpackage

// ### src/pcq_counter.sv
// pulse counter with quadrature decoder, single clock, sampled link inputs
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
// Operation
// RL1: domain reset bit holds counter logic in reset; release after two counter edges.
// RL2: domain reset restores limit, count and counter-side control state.
// RL3: in pin-clocked modes, register updates need 2-3 pin clocks to apply; here writes and commands apply on the next pin clock edge.
// RL4: software writes limit buffer only when count cannot pass it soon.
// RL5: default counter clock is the slow clock; primary pin is alternative.
// RL6: software holds domain reset while switching the clock source.
// RL7: guard passes sampled edge after level stable five slow-clock cycles.
// RL8: polarity picks falling edge when sampled; inverts quadrature direction.
// RL9: software changes polarity only while the counter is disabled.
// RL10: each pulse input may come from a chosen event-bus channel.
// RL11: all events share one interrupt output; flags tell the cause.
// RL12: down pulse at zero sets underflow, reloads limit or half limit.
// RL13: up pulse at limit sets overflow, reloads zero or half limit.
// RL14: quadrature direction change sets the reversal flag.
// RL15: secondary event field picks secondary increment events; it counts up.
// RL16: main event field: both, up only, down only, or never.
// RL17: second input direction bit: high input keeps direction, low reverses.
// RL18: midpoint wrap reloads half limit on every wrap; the secondary counter still wraps to zero.
// RL19: direction bit picks up or down in single modes, ignored in quadrature.
// RL20: mode field: disabled, sampled, pin-clocked single, pin-clocked quadrature.
// RL21: primary leading secondary decodes clockwise, lagging counter-clockwise.
// RL22: load-limit-now command copies buffer into live limit.
// RL23: interrupt is high while any enabled flag is set.
// RL24: set and clear registers act on ones only.
module pcq_counter #(
    parameter int CW     = 16,
    parameter int NCHAN  = 16
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // slow sampling clock, pulse pins and event bus
    input  wire logic              low_freq_clock,
    input  wire logic              primary_pulse_input,
    input  wire logic              secondary_pulse_input,
    input  wire logic [NCHAN-1:0]  peripheral_event_bus,
    // register port
    input  wire pcq_pkg::pcq_bus_s bus,
    output logic [31:0]            rdata,
    // interrupt
    output logic                   counter_interrupt
);
    // two-stage synchronisers for every asynchronous input
    logic [3+NCHAN-1:0] sy1_q, sy2_q;
    always_ff @(posedge clock) begin
        sy1_q <= {peripheral_event_bus, low_freq_clock, secondary_pulse_input,
                  primary_pulse_input};
        sy2_q <= sy1_q;
    end
    wire              pin0 = sy2_q[0];
    wire              pin1 = sy2_q[1];
    wire              lfc  = sy2_q[2];
    wire [NCHAN-1:0]  evb  = sy2_q[3+NCHAN-1:3];

    // software-side registers
    logic [15:0]  ctrl_q, inp_q, ien_q, route_q, frz_q;
    logic [CW-1:0] wrap_limit_buffer_q;
    wire wr_ctrl  = bus.wr && bus.addr == pcq_pkg::OFS_CTRL;
    wire wr_cmd   = bus.wr && bus.addr == pcq_pkg::OFS_CMD;
    wire wr_wrap_limit_buffer  = bus.wr && bus.addr == pcq_pkg::OFS_WRAP_LIMIT_BUFFER;
    wire wr_ifs   = bus.wr && bus.addr == pcq_pkg::OFS_IFS;
    wire wr_ifc   = bus.wr && bus.addr == pcq_pkg::OFS_IFC;
    wire wr_ien   = bus.wr && bus.addr == pcq_pkg::OFS_IEN;
    wire wr_route = bus.wr && bus.addr == pcq_pkg::OFS_ROUTE;
    wire wr_frz   = bus.wr && bus.addr == pcq_pkg::OFS_FREEZE;
    wire wr_inp   = bus.wr && bus.addr == pcq_pkg::OFS_INPUT;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_q  <= pcq_pkg::CTRL_RST;
            inp_q   <= 16'h0000;
            ien_q   <= 16'h0000;
            route_q <= 16'h0000;
            frz_q   <= 16'h0000;
            wrap_limit_buffer_q  <= CW'(pcq_pkg::TOP_RST);
        end else begin
            if (wr_ctrl)  ctrl_q  <= bus.wdata[15:0];
            if (wr_inp)   inp_q   <= bus.wdata[15:0];
            if (wr_ien)   ien_q   <= bus.wdata[15:0];
            if (wr_route) route_q <= bus.wdata[15:0];
            if (wr_frz)   frz_q   <= bus.wdata[15:0];
            if (wr_wrap_limit_buffer)  wrap_limit_buffer_q  <= bus.wdata[CW-1:0];  // see RL4
        end
    end

    wire domain_reset_enable = ctrl_q[pcq_pkg::RST_BIT];
    wire [1:0] mode_f = ctrl_q[pcq_pkg::MODE_LO +: 2];

    // counter clock: slow clock by default, primary pin in pin-clocked modes
    wire pin_clocked = mode_f == 2'(pcq_pkg::PCQ_PINCLK) ||
                       mode_f == 2'(pcq_pkg::PCQ_QUAD);       // see RL5
    // event-bus replacement of the inputs
    wire [pcq_pkg::SEL_W-1:0] chan = inp_q[pcq_pkg::SEL_LO +: pcq_pkg::SEL_W];
    wire ev_bit   = evb[chan];
    wire src0     = inp_q[pcq_pkg::S0EN_BIT] ? ev_bit : pin0; // see RL10
    wire src1     = inp_q[pcq_pkg::S1EN_BIT] ? ev_bit : pin1; // see RL10
    wire cclk     = pin_clocked ? src0 : lfc;                 // see RL5

    // counter clock edge detection on the system clock
    logic cclk_q, src0_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cclk_q <= 1'b0;
            src0_q <= 1'b0;
        end else begin
            cclk_q <= cclk;
            src0_q <= src0;
        end
    end
    wire tick = cclk & ~cclk_q;

    // domain reset: held while bit set, released on second counter tick
    logic [pcq_pkg::RST_SYNC-1:0] rel_q;
    always_ff @(posedge clock) begin
        if (!nrst || domain_reset_enable)
            rel_q <= '0;                                      // see RL1
        else if (tick)
            rel_q <= {rel_q[pcq_pkg::RST_SYNC-2:0], 1'b1};    // see RL1
    end
    wire dom_rst = domain_reset_enable || !rel_q[pcq_pkg::RST_SYNC-1];

    // settings copied into the counter domain on counter ticks; pin clock
    // therefore needs one pulse before a write applies
    logic [15:0] cctrl_q;
    logic        ltop_pend_q, lcnt_pend_q;
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst) begin
            cctrl_q <= pcq_pkg::CTRL_RST;                     // see RL2
        end else if (tick) begin
            cctrl_q <= ctrl_q;                                // see RL3
        end
    end
    // command strobes wait for the next counter tick; set wins over consume
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst) begin
            ltop_pend_q <= 1'b0;
            lcnt_pend_q <= 1'b0;
        end else begin
            ltop_pend_q <= (wr_cmd && bus.wdata[pcq_pkg::CMD_LTOP]) || (ltop_pend_q && !tick);
            lcnt_pend_q <= (wr_cmd && bus.wdata[pcq_pkg::CMD_LCNT]) || (lcnt_pend_q && !tick);
        end
    end

    wire [1:0] cmode  = cctrl_q[pcq_pkg::MODE_LO +: 2];
    wire       c_samp = cmode == 2'(pcq_pkg::PCQ_SAMPLED);
    wire       c_pin  = cmode == 2'(pcq_pkg::PCQ_PINCLK);
    wire       c_quad = cmode == 2'(pcq_pkg::PCQ_QUAD);
    wire       c_edge = cctrl_q[pcq_pkg::EDGE_BIT];
    wire       c_midpoint_wrap_enable = cctrl_q[pcq_pkg::MIDPOINT_WRAP_ENABLE_BIT];
    wire [1:0] c_cev  = cctrl_q[pcq_pkg::MAIN_COUNT_EVENTS_LO +: 2];
    wire [1:0] c_aev  = cctrl_q[pcq_pkg::AUXEV_LO +: 2];

    // pulse width guard in sampled mode, counted in slow-clock ticks
    logic [2:0] fcnt_q;
    logic       pulse_width_guard_q, in_q;
    wire        raw_in = src0;
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst) begin
            fcnt_q <= 3'h0;
            pulse_width_guard_q <= 1'b0;
            in_q   <= 1'b0;
        end else if (tick) begin
            in_q <= raw_in;
            if (raw_in != in_q)
                fcnt_q <= 3'h1;
            else if (fcnt_q < 3'(pcq_pkg::PULSE_WIDTH_GUARD_CYC))
                fcnt_q <= fcnt_q + 3'h1;
            if (!cctrl_q[pcq_pkg::PULSE_WIDTH_GUARD_BIT])
                pulse_width_guard_q <= raw_in;
            else if (raw_in == in_q && fcnt_q == 3'(pcq_pkg::PULSE_WIDTH_GUARD_CYC - 1))
                pulse_width_guard_q <= raw_in;                             // see RL7
        end
    end
    logic pulse_width_guard_prev_q;
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst)
            pulse_width_guard_prev_q <= 1'b0;
        else if (tick)
            pulse_width_guard_prev_q <= pulse_width_guard_q;
    end
    wire samp_edge = c_edge ? (pulse_width_guard_prev_q & ~pulse_width_guard_q)         // see RL8
                            : (~pulse_width_guard_prev_q & pulse_width_guard_q);        // see RL8

    // single-input direction: 1 means down
    wire s_down = cctrl_q[pcq_pkg::S1DIR_BIT] && !src1
                  ? ~cctrl_q[pcq_pkg::DIR_BIT]                // see RL17
                  : cctrl_q[pcq_pkg::DIR_BIT];                // see RL19

    // quadrature: secondary sampled on both primary edges
    logic s1_last_q, qdir_q;
    wire  any0 = src0 ^ src0_q;
    wire  quad_tick = c_quad && any0;
    // with primary leading, secondary low on primary rise: clockwise (up)
    wire  q_en   = src1 != s1_last_q;
    wire  q_down = (src0 ? src1 : ~src1) ^ c_edge;            // see RL21 RL8
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst) begin
            s1_last_q <= 1'b0;
            qdir_q    <= 1'b0;
        end else if (quad_tick) begin
            s1_last_q <= src1;
            if (q_en)
                qdir_q <= q_down;
        end
    end
    wire dir_change = quad_tick && q_en && q_down != qdir_q;  // see RL14

    // count events
    wire ev       = (c_samp && tick && samp_edge) || (c_pin && tick) ||
                    (quad_tick && q_en);                      // see RL20
    wire ev_down  = c_quad ? q_down : s_down;                 // see RL19
    wire ev_up_p  = ev && !ev_down;
    wire ev_dn_p  = ev && ev_down;
    wire do_up    = ev_up_p && (c_cev == pcq_pkg::EV_BOTH ||
                                c_cev == pcq_pkg::EV_UP);     // see RL16
    wire do_dn    = ev_dn_p && (c_cev == pcq_pkg::EV_BOTH ||
                                c_cev == pcq_pkg::EV_DOWN);   // see RL16
    wire do_aux   = (ev_up_p && (c_aev == pcq_pkg::AX_UP || c_aev == pcq_pkg::AX_BOTH)) ||
                    (ev_dn_p && (c_aev == pcq_pkg::AX_DOWN || c_aev == pcq_pkg::AX_BOTH));

    logic [CW-1:0] cnt_q, top_q, aux_q;
    wire  [CW-1:0] half = top_q >> 1;
    wire  uf = do_dn && cnt_q == '0;                          // see RL12
    wire  of = do_up && cnt_q == top_q;                       // see RL13
    wire  aof = do_aux && aux_q == top_q;
    always_ff @(posedge clock) begin
        if (!nrst || dom_rst) begin
            cnt_q <= '0;                                      // see RL2
            top_q <= CW'(pcq_pkg::TOP_RST);                   // see RL2
            aux_q <= '0;
        end else begin
            if (ltop_pend_q && tick)
                top_q <= wrap_limit_buffer_q;                              // see RL22
            if (lcnt_pend_q && tick)
                cnt_q <= wrap_limit_buffer_q;
            else if (uf)
                cnt_q <= c_midpoint_wrap_enable ? half : top_q;               // see RL12 RL18
            else if (of)
                cnt_q <= c_midpoint_wrap_enable ? half : '0;                  // see RL13 RL18
            else if (do_up)
                cnt_q <= cnt_q + CW'(1);
            else if (do_dn)
                cnt_q <= cnt_q - CW'(1);
            if (aof)
                aux_q <= '0;
            else if (do_aux)
                aux_q <= aux_q + CW'(1);                      // see RL15
        end
    end

    // event flags: hardware set wins over software clear
    logic [pcq_pkg::NFLAG-1:0] flag_q;
    wire  [pcq_pkg::NFLAG-1:0] hw_set = {aof, dir_change, of, uf};
    wire  [pcq_pkg::NFLAG-1:0] sw_set = wr_ifs ? bus.wdata[pcq_pkg::NFLAG-1:0] : '0;
    wire  [pcq_pkg::NFLAG-1:0] sw_clr = wr_ifc ? bus.wdata[pcq_pkg::NFLAG-1:0] : '0;
    always_ff @(posedge clock) begin
        if (!nrst)
            flag_q <= '0;
        else
            flag_q <= (flag_q & ~sw_clr) | sw_set | hw_set;   // see RL24
    end
    assign counter_interrupt =
        |(flag_q & ien_q[pcq_pkg::NFLAG-1:0]);                // see RL11 RL23

    // register read, data one cycle after the strobe
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (bus.addr)
            pcq_pkg::OFS_CTRL:   rmux = {16'h0000, ctrl_q};
            pcq_pkg::OFS_STATUS: rmux = {31'h0, qdir_q};
            pcq_pkg::OFS_CNT:    rmux = 32'(cnt_q);
            pcq_pkg::OFS_TOP:    rmux = 32'(top_q);
            pcq_pkg::OFS_WRAP_LIMIT_BUFFER:   rmux = 32'(wrap_limit_buffer_q);
            pcq_pkg::OFS_IF:     rmux = 32'(flag_q);
            pcq_pkg::OFS_IEN:    rmux = {16'h0000, ien_q};
            pcq_pkg::OFS_ROUTE:  rmux = {16'h0000, route_q};
            pcq_pkg::OFS_FREEZE: rmux = {16'h0000, frz_q};
            pcq_pkg::OFS_SYNC:   rmux = {29'h0, lcnt_pend_q | ltop_pend_q,
                                         ltop_pend_q, cctrl_q != ctrl_q};
            pcq_pkg::OFS_AUX:    rmux = 32'(aux_q);
            pcq_pkg::OFS_INPUT:  rmux = {16'h0000, inp_q};
            default:             rmux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!nrst)
            rdata <= 32'h0000_0000;
        else
            rdata <= bus.rd ? rmux : 32'h0000_0000;
    end
endmodule

// ### bench/pcq_counter_chk.sv
// assertion checker for the pulse counter register port and interrupt
`timescale 1ns/100ps
module pcq_counter_chk #(
    parameter int CW    = 16,
    parameter int NCHAN = 16
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              nrst,
    // slow clock, pins and event bus
    input wire logic              low_freq_clock,
    input wire logic              primary_pulse_input,
    input wire logic              secondary_pulse_input,
    input wire logic [NCHAN-1:0]  peripheral_event_bus,
    // register port and interrupt
    input wire pcq_pkg::pcq_bus_s bus,
    input wire logic [31:0]       rdata,
    input wire logic              counter_interrupt
);
    logic [3:0]  ien_q;
    logic [15:0] ctrl_q;
    logic        cfg_q;
    wire         wr_ien  = bus.wr && bus.addr == pcq_pkg::OFS_IEN;
    wire         wr_ctrl = bus.wr && bus.addr == pcq_pkg::OFS_CTRL;
    wire         wr_cmd  = bus.wr && bus.addr == pcq_pkg::OFS_CMD;
    wire         rd_wo   = bus.rd && (bus.addr == pcq_pkg::OFS_CMD ||
                           bus.addr == pcq_pkg::OFS_IFS || bus.addr == pcq_pkg::OFS_IFC);

    // shadows of software-visible state; counter-side state is not modelled
    always_ff @(posedge clock) begin
        ien_q  <= !nrst ? 4'h0 : (wr_ien ? bus.wdata[3:0] : ien_q);
        ctrl_q <= !nrst ? 16'h0000 : (wr_ctrl ? bus.wdata[15:0] & 16'hcf3f : ctrl_q);
        cfg_q  <= nrst && (cfg_q || wr_ctrl || wr_cmd);
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_set_enabled;
        bus.wr && bus.addr == pcq_pkg::OFS_IFS && (bus.wdata[3:0] & ien_q) != 4'h0;
    endsequence
    sequence s_rd(logic [7:0] a);
        bus.rd && bus.addr == a;
    endsequence

    a_irq_needs_enable: assert property (ien_q == 4'h0 |-> !counter_interrupt)
        else $error("interrupt high with all enables clear");
    a_set_raises_irq: assert property (s_set_enabled |=> counter_interrupt)
        else $error("enabled flag set did not raise interrupt");
    a_ien_readback: assert property (s_rd(pcq_pkg::OFS_IEN) |=> rdata[3:0] == ien_q)
        else $error("enable register readback wrong");
    a_ctrl_readback: assert property (s_rd(pcq_pkg::OFS_CTRL) |=>
        (rdata[15:0] & 16'hcf3f) == ctrl_q)
        else $error("control register readback wrong");
    a_top_reset_val: assert property (bus.rd && bus.addr == pcq_pkg::OFS_TOP && !cfg_q
        |=> rdata[15:0] == pcq_pkg::TOP_RST)
        else $error("limit not at reset value");
    a_cnt_reset_val: assert property (bus.rd && bus.addr == pcq_pkg::OFS_CNT && !cfg_q
        |=> rdata == 32'h0)
        else $error("count not zero after reset");
    a_wo_reads_zero: assert property (rd_wo |=> rdata == 32'h0)
        else $error("write-only register read nonzero");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind pcq_counter pcq_counter_chk #(.CW(CW), .NCHAN(NCHAN)) u_chk (
    .clock(clock), .nrst(nrst), .low_freq_clock(low_freq_clock),
    .primary_pulse_input(primary_pulse_input), .secondary_pulse_input(secondary_pulse_input),
    .peripheral_event_bus(peripheral_event_bus), .bus(bus), .rdata(rdata),
    .counter_interrupt(counter_interrupt)
);

// ### bench/pcq_encoder.sv
// rotary encoder and pulse sensor model driving the two pulse pins
`timescale 1ns/100ps
module pcq_encoder (
    // bench clock
    input wire logic clock,
    // pulse pins
    output logic     phase_a,
    output logic     phase_b
);
    localparam int HOLD = 48;

    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // default level lasts six slow samples, longer than the pulse guard
    task automatic pulses(input int n, input int w = HOLD);
        repeat (n) begin
            phase_a <= 1'b1;
            repeat (w) @(posedge clock);
            phase_a <= 1'b0;
            repeat (w) @(posedge clock);
        end
    endtask

    // forward steps make phase a lead phase b; the shaft holds its position after
    task automatic steps(input logic fwd, input int n);
        repeat (n) begin
            if (fwd == (phase_a == phase_b)) phase_a <= !phase_a;
            else phase_b <= !phase_b;
            repeat (HOLD / 2) @(posedge clock);
        end
    endtask
endmodule

// ### bench/pcq_counter_tb.sv
// self-checking bench for the pulse counter
`timescale 1ns/100ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, act, exp); end end
module pcq_counter_tb;
    logic              clock;
    logic              nrst;
    logic              low_freq_clock;
    logic              phase_a;
    logic              phase_b;
    logic [15:0]       peripheral_event_bus;
    pcq_pkg::pcq_bus_s bus;
    logic [31:0]       rdata;
    logic              counter_interrupt;
    logic [31:0]       q;
    logic [31:0]       v;
    int                n_fail = 0;
    int                check_count = 0;

    pcq_counter #(.CW(16), .NCHAN(16)) u_dut (
        .clock(clock), .nrst(nrst), .low_freq_clock(low_freq_clock),
        .primary_pulse_input(phase_a), .secondary_pulse_input(phase_b),
        .peripheral_event_bus(peripheral_event_bus), .bus(bus), .rdata(rdata),
        .counter_interrupt(counter_interrupt)
    );
    pcq_encoder u_enc (.clock(clock), .phase_a(phase_a), .phase_b(phase_b));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // slow clock offset so its edges never meet the bench clock edges
    initial begin
        low_freq_clock = 1'b0;
        #17;
        forever #400 low_freq_clock = ~low_freq_clock;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
        @(posedge clock);
    endtask
    task automatic bus_rd(input logic [7:0] a);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        // read data stand only in the cycle after the strobe
        @(negedge clock);
        q = rdata;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus_rd(a);
        `CHK(q, e)
    endtask

    task automatic t_reset();
        rchk(pcq_pkg::OFS_TOP, 32'h00ff);
        rchk(pcq_pkg::OFS_CNT, 32'h0);
        rchk(pcq_pkg::OFS_CTRL, 32'h0);
        bus_wr(8'h34, 32'hffff);
        rchk(8'h34, 32'h0);
        rchk(pcq_pkg::OFS_IF, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_flags();
        bus_wr(pcq_pkg::OFS_IEN, 32'h0);
        bus_wr(pcq_pkg::OFS_IFS, 32'hf);
        rchk(pcq_pkg::OFS_IF, 32'hf);
        `CHK(counter_interrupt, 1'b0)
        bus_wr(pcq_pkg::OFS_IFC, 32'h5);
        bus_wr(pcq_pkg::OFS_IFS, 32'h0);
        rchk(pcq_pkg::OFS_IF, 32'ha);
        bus_wr(pcq_pkg::OFS_IEN, 32'h8);
        `CHK(counter_interrupt, 1'b1)
        rchk(pcq_pkg::OFS_IEN, 32'h8);
        bus_wr(pcq_pkg::OFS_IFC, 32'hf);
        `CHK(counter_interrupt, 1'b0)
        bus_wr(pcq_pkg::OFS_IFS, 32'h8);
        `CHK(counter_interrupt, 1'b1)
        bus_wr(pcq_pkg::OFS_IFC, 32'h8);
        `CHK(counter_interrupt, 1'b0)
        $display("test flags done");
    endtask

    task automatic t_wrap();
        bus_wr(pcq_pkg::OFS_WRAP_LIMIT_BUFFER, 32'h3);
        bus_wr(pcq_pkg::OFS_CMD, 32'h2);
        idle(32);
        rchk(pcq_pkg::OFS_TOP, 32'h3);
        bus_wr(pcq_pkg::OFS_IEN, 32'h2);
        bus_wr(pcq_pkg::OFS_CTRL, 32'h4001);
        idle(32);
        u_enc.pulses(3);
        rchk(pcq_pkg::OFS_CNT, 32'h3);
        rchk(pcq_pkg::OFS_AUX, 32'h3);
        `CHK(counter_interrupt, 1'b0)
        u_enc.pulses(1);
        rchk(pcq_pkg::OFS_CNT, 32'h0);
        bus_rd(pcq_pkg::OFS_IF);
        `CHK(q[1:0], 2'h2)
        `CHK(counter_interrupt, 1'b1)
        bus_wr(pcq_pkg::OFS_IFC, 32'hf);
        // down count from zero with midpoint wrap lands on half the limit
        bus_wr(pcq_pkg::OFS_CTRL, 32'h0105);
        idle(32);
        u_enc.pulses(1);
        rchk(pcq_pkg::OFS_CNT, 32'h1);
        bus_rd(pcq_pkg::OFS_IF);
        `CHK(q[0], 1'b1)
        bus_wr(pcq_pkg::OFS_CTRL, 32'h0405);
        idle(32);
        u_enc.pulses(1);
        rchk(pcq_pkg::OFS_CNT, 32'h1);
        // low second input turns the down setting into an up count
        bus_wr(pcq_pkg::OFS_CTRL, 32'h0205);
        idle(32);
        u_enc.pulses(1);
        rchk(pcq_pkg::OFS_CNT, 32'h2);
        $display("test wrap done");
    endtask

    task automatic t_filter();
        bus_wr(pcq_pkg::OFS_CTRL, 32'h11);
        idle(32);
        // two slow samples per level: the guard must drop it
        u_enc.pulses(1, 16);
        rchk(pcq_pkg::OFS_CNT, 32'h2);
        bus_wr(pcq_pkg::OFS_CMD, 32'h1);
        idle(16);
        rchk(pcq_pkg::OFS_CNT, 32'h3);
        u_enc.pulses(1);
        rchk(pcq_pkg::OFS_CNT, 32'h0);
        $display("test filter done");
    endtask

    task automatic t_evbus();
        bus_wr(pcq_pkg::OFS_CTRL, 32'h1);
        bus_wr(pcq_pkg::OFS_INPUT, 32'h45);
        idle(32);
        // other channels move against the chosen one and must not count
        repeat (2) begin
            peripheral_event_bus <= 16'h0020;
            idle(32);
            peripheral_event_bus <= 16'hffdf;
            idle(32);
        end
        peripheral_event_bus <= 16'h0000;
        rchk(pcq_pkg::OFS_CNT, 32'h2);
        bus_wr(pcq_pkg::OFS_INPUT, 32'h0);
        $display("test event bus done");
    endtask

    task automatic t_quad();
        // pin-clocked single mode: the first pulses only carry the release across
        bus_wr(pcq_pkg::OFS_CTRL, 32'h22);
        bus_wr(pcq_pkg::OFS_CTRL, 32'h02);
        u_enc.pulses(3);
        bus_rd(pcq_pkg::OFS_CNT);
        v = q;
        `CHK(v[31:1], 31'h0)
        u_enc.pulses(2);
        rchk(pcq_pkg::OFS_CNT, v + 32'h2);
        bus_wr(pcq_pkg::OFS_CTRL, 32'h23);
        bus_wr(pcq_pkg::OFS_CTRL, 32'h03);
        u_enc.steps(1'b1, 24);
        bus_rd(pcq_pkg::OFS_STATUS);
        `CHK(q[0], 1'b0)
        bus_wr(pcq_pkg::OFS_IFC, 32'hf);
        u_enc.steps(1'b0, 24);
        bus_rd(pcq_pkg::OFS_IF);
        `CHK(q[2], 1'b1)
        bus_rd(pcq_pkg::OFS_STATUS);
        `CHK(q[0], 1'b1)
        bus_wr(pcq_pkg::OFS_CTRL, 32'h23);
        idle(4);
        rchk(pcq_pkg::OFS_CNT, 32'h0);
        rchk(pcq_pkg::OFS_TOP, 32'h00ff);
        $display("test quadrature done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        bus = '0;
        nrst = 1'b0;
        peripheral_event_bus = '0;
        idle(16);
        nrst <= 1'b1;
        // domain reset needs two slow ticks after release before counting
        idle(24);
        t_reset();
        t_flags();
        t_wrap();
        t_filter();
        t_evbus();
        t_quad();
        print_verdict();
    end

    // all tests need about 3000 cycles; nearly seven times that (20000 cycles) means a hang
    initial begin
        #2000000;
        n_fail++;
        $display("watchdog expired at %0t", $time);
        print_verdict();
    end
endmodule
